// ### core/adccr_bank.sv
// APB register bank with offset and gain correction of conversion results
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adccr_regs.svh"
module adccr_bank
  import adccr_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] aux_pin_in, // Aux pin levels from pads
  output logic [3:0] aux_pin_out, // Aux pin drive levels
  output logic soft_sleep, // Software power-down
  output logic status_byte_enable, // Status byte on data reads
  output logic check_code_enable, // Check code enabled
  output logic serial_auto_reset_enable, // Serial auto-reset enabled
  output logic [1:0] vref_pos_select, // Positive reference route
  output logic [1:0] vref_neg_select, // Negative reference route
  input wire logic raw_valid, // Raw sample strobe
  input wire logic [23:0] raw_sample, // Raw signed sample
  output logic result_valid, // Corrected sample strobe
  output logic [23:0] result_sample // Corrected signed sample
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic [5:0] word_index(input logic [7:0] addr);
    word_index = addr[7:2];
  endfunction

  function automatic logic [23:0] byte_put(input logic [23:0] word, input logic [1:0] lane,
                                           input logic [7:0] value);
    logic [23:0] w;
    w = word;
    w[lane*8 +: 8] = value;
    byte_put = w;
  endfunction

  logic wr_en;
  logic rd_hit;
  logic [5:0] idx;
  logic [3:0] aux_sync1_reg;
  logic [3:0] aux_sync2_reg;
  adccr_option_t option_reg;
  adccr_vref_t vref_reg;
  logic [23:0] offset_word_reg;
  logic [23:0] gain_word_reg;
  logic [23:0] raw_reg;
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [26:0] scaled;
  logic [23:0] sat_value;
  logic [31:0] rdata_next;

  assign idx = word_index(paddr);
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  assign rd_hit = (idx >= {2'b00, `ADCCR_IDX_OPTION}) && (idx <= {1'b0, `ADCCR_IDX_RESULT});

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_sync1_reg <= 4'h0;
      aux_sync2_reg <= 4'h0;
    end else begin
      aux_sync1_reg <= aux_pin_in;
      aux_sync2_reg <= aux_sync1_reg;
    end
  end

  // ----------------------------------------
  // Option and reference registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_reg <= `ADCCR_OPTION_RESET;
    end else if (wr_en && idx == {2'b00, `ADCCR_IDX_OPTION}) begin
      option_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_reg <= `ADCCR_VREF_RESET;
    end else if (wr_en && idx == {2'b00, `ADCCR_IDX_VREF}) begin
      vref_reg <= {4'h0, pwdata[3:0]};
    end
  end

  assign soft_sleep = option_reg.soft_sleep;
  assign status_byte_enable = option_reg.status_byte_enable;
  assign check_code_enable = option_reg.check_code_enable;
  assign serial_auto_reset_enable = option_reg.serial_auto_reset_enable;
  assign aux_pin_out = option_reg.aux_pin_level;
  assign vref_pos_select = vref_reg.vref_pos_select;
  assign vref_neg_select = vref_reg.vref_neg_select;

  // ----------------------------------------
  // Calibration words
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_word_reg <= `ADCCR_OFS_RESET;
    end else if (wr_en && idx >= {2'b00, `ADCCR_IDX_OFS_LOW}
                 && idx <= {2'b00, `ADCCR_IDX_OFS_HIGH}) begin
      offset_word_reg <= byte_put(offset_word_reg, 2'(idx - 6'd7), pwdata[7:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_word_reg <= `ADCCR_GAIN_RESET;
    end else if (wr_en && idx >= {2'b00, `ADCCR_IDX_GAIN_LOW}
                 && idx <= {2'b00, `ADCCR_IDX_GAIN_HIGH}) begin
      gain_word_reg <= byte_put(gain_word_reg, 2'(idx - 6'd10), pwdata[7:0]);
    end
  end

  // ----------------------------------------
  // Correction datapath
  // ----------------------------------------
  assign diff = $signed({raw_sample[23], raw_sample}) - $signed({offset_word_reg[23],
                offset_word_reg});
  assign prod = diff * $signed({1'b0, gain_word_reg});
  assign scaled = prod[`ADCCR_GAIN_SHIFT + 26:`ADCCR_GAIN_SHIFT];

  always_comb begin
    if (scaled > 27'sh07FFFFF) begin
      sat_value = 24'h7FFFFF;
    end else if (scaled < -27'sh0800000) begin
      sat_value = 24'h800000;
    end else begin
      sat_value = scaled[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid <= 1'b0;
      result_sample <= 24'h000000;
      raw_reg <= 24'h000000;
    end else begin
      result_valid <= raw_valid;
      if (raw_valid) begin
        result_sample <= sat_value;
        raw_reg <= raw_sample;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata_next = 32'h00000000;
    unique case (idx)
      {2'b00, `ADCCR_IDX_OPTION}: rdata_next = {24'h0, option_reg[7:4], aux_sync2_reg};
      {2'b00, `ADCCR_IDX_VREF}: rdata_next = {24'h0, vref_reg};
      {2'b00, `ADCCR_IDX_OFS_LOW}: rdata_next = {24'h0, offset_word_reg[7:0]};
      {2'b00, `ADCCR_IDX_OFS_MID}: rdata_next = {24'h0, offset_word_reg[15:8]};
      {2'b00, `ADCCR_IDX_OFS_HIGH}: rdata_next = {24'h0, offset_word_reg[23:16]};
      {2'b00, `ADCCR_IDX_GAIN_LOW}: rdata_next = {24'h0, gain_word_reg[7:0]};
      {2'b00, `ADCCR_IDX_GAIN_MID}: rdata_next = {24'h0, gain_word_reg[15:8]};
      {2'b00, `ADCCR_IDX_GAIN_HIGH}: rdata_next = {24'h0, gain_word_reg[23:16]};
      {2'b00, `ADCCR_IDX_SPARE_ONES}: rdata_next = {24'h0, `ADCCR_SPARE_ONES_VAL};
      {2'b00, `ADCCR_IDX_SPARE_ZA}: rdata_next = 32'h00000000;
      {2'b00, `ADCCR_IDX_SPARE_ZB}: rdata_next = 32'h00000000;
      {1'b0, `ADCCR_IDX_RAW}: rdata_next = {8'h00, raw_reg};
      {1'b0, `ADCCR_IDX_RESULT}: rdata_next = {8'h00, result_sample};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  // Captured in the setup phase, so the access phase sees a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end else begin
      prdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ### core/adccr_regs.svh
// Register offsets, field positions and reset values of the calibration bank
`ifndef ADCCR_REGS_SVH
`define ADCCR_REGS_SVH
// Printed offsets are indices; byte address is four times the index
`define ADCCR_IDX_OPTION 4'h5
`define ADCCR_IDX_VREF 4'h6
`define ADCCR_IDX_OFS_LOW 4'h7
`define ADCCR_IDX_OFS_MID 4'h8
`define ADCCR_IDX_OFS_HIGH 4'h9
`define ADCCR_IDX_GAIN_LOW 4'hA
`define ADCCR_IDX_GAIN_MID 4'hB
`define ADCCR_IDX_GAIN_HIGH 4'hC
`define ADCCR_IDX_SPARE_ONES 4'hD
`define ADCCR_IDX_SPARE_ZA 4'hE
`define ADCCR_IDX_SPARE_ZB 4'hF
// Raw conversion sample input/output registers (chosen)
`define ADCCR_IDX_RAW 5'h10
`define ADCCR_IDX_RESULT 5'h11
`define ADCCR_OPTION_RESET 8'h00
`define ADCCR_VREF_RESET 8'h05
`define ADCCR_OFS_RESET 24'h000000
`define ADCCR_GAIN_RESET 24'h400000
`define ADCCR_SPARE_ONES_VAL 8'hFF
`define ADCCR_BIT_SLEEP 7
`define ADCCR_BIT_STATUS 6
`define ADCCR_BIT_CHECK 5
`define ADCCR_BIT_AUTORST 4
`define ADCCR_GAIN_SHIFT 22
`endif

// ### core/adccr_pkg.sv
// Types of the calibration register bank
package adccr_pkg;
  typedef enum logic [1:0] {
    VSEL_RESERVED,
    VSEL_SUPPLY,
    VSEL_PIN,
    VSEL_INPUT
  } adccr_vsel_t;
  typedef struct packed {
    logic soft_sleep;
    logic status_byte_enable;
    logic check_code_enable;
    logic serial_auto_reset_enable;
    logic [3:0] aux_pin_level;
  } adccr_option_t;
  typedef struct packed {
    logic [3:0] zero;
    adccr_vsel_t vref_pos_select;
    adccr_vsel_t vref_neg_select;
  } adccr_vref_t;
endpackage

// ### tb/adccr_bank_assertions.sv
// Concurrent checks on the calibration bank ports
`timescale 1ns/1ps
`default_nettype none
module adccr_bank_assertions
  import adccr_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic [3:0] aux_pin_out, // Pin drive
  input wire logic soft_sleep, // Power-down flag
  input wire logic status_byte_enable, // Status byte flag
  input wire logic check_code_enable, // Check code flag
  input wire logic serial_auto_reset_enable, // Auto-reset flag
  input wire logic raw_valid, // Raw sample strobe
  input wire logic result_valid, // Result strobe
  input wire logic [1:0] vref_pos_select, // Positive route
  input wire logic [1:0] vref_neg_select // Negative route
);
  logic [3:0] flags;
  logic [3:0] vref;
  assign flags = {soft_sleep, status_byte_enable, check_code_enable, serial_auto_reset_enable};
  assign vref = {vref_pos_select, vref_neg_select};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc(logic [7:0] a);
    psel && penable && pready && paddr == a;
  endsequence
  sequence wr(logic [7:0] a);
    acc(a) ##0 (pwrite && pstrb[0]);
  endsequence
  option_bits_a: assert property (wr(8'h14) |=> flags == $past(pwdata[7:4]))
    else $error("option flags wrong");
  pin_drive_a: assert property (wr(8'h14) |=> aux_pin_out == $past(pwdata[3:0]))
    else $error("pin drive wrong");
  vref_write_a: assert property (wr(8'h18) |=> vref == $past(pwdata[3:0]))
    else $error("reference route wrong");
  spare_ones_a: assert property (acc(8'h34) ##0 !pwrite |-> prdata == 32'h000000FF)
    else $error("spare ones read wrong");
  spare_zero_a: assert property ((acc(8'h38) or acc(8'h3C)) ##0 !pwrite |-> prdata == 32'h0)
    else $error("spare zero read wrong");
  ro_ignore_a: assert property (psel && penable && pwrite && (paddr >= 8'h34 || !pstrb[0])
    |=> $stable({flags, aux_pin_out, vref})) else $error("ignored write changed state");
  result_time_a: assert property (result_valid == $past(raw_valid))
    else $error("result strobe timing wrong");
  reset_state_a: assert property ($rose(presetn) |-> {flags, aux_pin_out, vref} == 12'h005)
    else $error("reset state wrong");
  err_map_a: assert property (psel && penable |-> pslverr == (paddr[7:2] < 6'h05 ||
    paddr[7:2] > 6'h11)) else $error("error response wrong");
endmodule
bind adccr_bank adccr_bank_assertions i_chk (.*);
`default_nettype wire

// ### tb/adccr_host.sv
// APB host model driving the register bank
`timescale 1ns/1ps
`default_nettype none
module adccr_host (
  input wire logic pclk, // Clock
  input wire logic pready, // Ready
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [7:0] paddr, // Address
  output logic [31:0] pwdata, // Write data
  output logic [3:0] pstrb // Strobes
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a == 8'h18) ? (d & 32'h0000000F) : d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench of the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adccr_pkg::*;
  localparam logic [87:0] RV = 88'h00_05_00_00_00_00_00_40_FF_00_00;
  logic pclk = 0, presetn = 0, raw_valid = 0;
  logic psel, penable, pwrite, pready, pslverr, result_valid;
  logic soft_sleep, status_byte_enable, check_code_enable, serial_auto_reset_enable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb, aux_pin_out, aux_pin_in = 0;
  logic [1:0] vref_pos_select, vref_neg_select;
  logic [23:0] raw_sample = 0, result_sample, ofs, gain, last_raw;
  int failures = 0, compares = 0, seed = 32'hc583;
  logic [32:0] rd_q[$];
  logic [23:0] res_q[$];
  always #10 pclk = ~pclk;
  adccr_bank i_dut (.*);
  adccr_host i_host (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
  task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back({a[7:2] < 6'h05 || a[7:2] > 6'h11, e});
    i_host.xfer(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_host.xfer(1'b1, a, v, 4'hF);
  endtask
  function automatic logic [23:0] fix(input logic [23:0] r);
    longint p;
    p = (longint'($signed(r)) - longint'($signed(ofs))) * longint'(gain);
    p = p >>> 22;
    if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
    if (p < -64'sh800000) p = -64'sh800000;
    return p[23:0];
  endfunction
  task automatic samp(input logic [23:0] r);
    res_q.push_back(fix(r));
    @(posedge pclk);
    raw_valid <= 1'b1;
    raw_sample <= r;
    @(posedge pclk);
    raw_valid <= 1'b0;
    raw_sample <= ~r;
  endtask
  task automatic complete_run;
    if (rd_q.size() != 0 || res_q.size() != 0) begin
      failures++;
    end
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("prdata", {pslverr, prdata}, rd_q.pop_front());
    end
    if (result_valid === 1'b1) begin
      check("result_sample", {9'h0, result_sample}, {9'h0, res_q.pop_front()});
    end
  end
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  initial begin
    ofs = 24'h0;
    gain = 24'h400000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 13; i < 16; i++) wr(8'(i * 4), 32'h0000005A);
    i_host.xfer(1'b1, 8'h14, 32'h000000FF, 4'h0);
    for (int i = 5; i < 16; i++) rd(8'(i * 4), {24'h0, RV[(15 - i) * 8 +: 8]});
    rd(8'h00, 32'h0);
    rd(8'h48, 32'h0);
    repeat (3) samp(24'($random(seed)));
    repeat (6) begin
      d = $random(seed);
      aux_pin_in <= d[11:8];
      wr(8'h14, {24'h0, d[7:0]});
      rd(8'h14, {24'h0, d[7:4], d[11:8]});
    end
    for (int c = 1; c < 4; c++) begin
      wr(8'h18, {24'h0, 4'hF, 2'(c), 2'(4 - c)});
      rd(8'h18, {28'h0, 2'(c), 2'(4 - c)});
    end
    repeat (4) begin
      ofs = 24'($random(seed));
      gain = 24'($random(seed));
      for (int b = 0; b < 3; b++) begin
        wr(8'(8'h1C + 4 * b), {24'h0, ofs[8 * b +: 8]});
        wr(8'(8'h28 + 4 * b), {24'h0, gain[8 * b +: 8]});
      end
      rd(8'h20, {24'h0, ofs[15:8]});
      rd(8'h30, {24'h0, gain[23:16]});
      repeat (3) begin
        last_raw = 24'($random(seed));
        samp(last_raw);
      end
      rd(8'h40, {8'h00, last_raw});
      rd(8'h44, {8'h00, fix(last_raw)});
    end
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h30, 32'h00000040);
    rd(8'h18, 32'h00000005);
    repeat (3) @(posedge pclk);
    complete_run;
  end
endmodule
`default_nettype wire
